// ==== pswc_pkg.sv ====
// How it works
// (R01) Each recognised pulse moves wiper one position
// (R02) Inputs idle high; falling edge starts pulse
// (R03) Dual mode needs all inputs open
// (R04) Digital step input works in every mode
// (R05) Held over one second: step every 100 ms
// (R06) Single and digital modes reverse at ends
// (R07) One second idle reverses direction; code does this in single mode only, never in dual mode
// (R08) Dual mode: up raises, down lowers
// (R09) Dual mode holds at end, no reversal
// (R10) Contact inputs debounced inside
// (R11) Power-up loads last saved position
// (R12) Changed position saved after two seconds
// (R13) First change after power-up always saved
// (R14) Later saves need fourth bit change
// (R15) Keep power two seconds after change
// (R16) After wear-out keep working, stop saving
// (R17) Mode detected within 10 us
// (R18) Digital pulses low at least 1 us
// (R19) Contact pulses low at least 1 ms
// (R20) Gaps under 1 ms merge pulses
// (R21) Pulses within one second keep direction
// (R22) Hold and idle timing within ten percent
// (R23) Six-bit clamped position plus direction flag
package pswc_pkg;
	localparam int          CLK_PERIOD_NS              = 5;
	localparam int          CLK_KHZ                    = 200000;
	localparam int          MS_CYC                     = CLK_KHZ;
	localparam int          CONTACT_STEP_MIN_WIDTH_MS  = 1;
	localparam int          CONTACT_STEP_MIN_WIDTH_CYC = CONTACT_STEP_MIN_WIDTH_MS * CLK_KHZ;
	localparam int          DIGITAL_STEP_MIN_WIDTH_NS  = 1000;
	localparam int          DIGITAL_STEP_MIN_WIDTH_CYC =
		(DIGITAL_STEP_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          MODE_DETECT_TIME_NS        = 10000;
	localparam int          MODE_DETECT_TIME_CYC       = MODE_DETECT_TIME_NS / CLK_PERIOD_NS;
	localparam logic [10:0] HOLD_MS                    = 11'h3e8;
	localparam logic [10:0] REPEAT_MS                  = 11'h064;
	localparam logic [10:0] IDLE_MS                    = 11'h3e8;
	localparam logic [10:0] SAVE_MS                    = 11'h7d0;
	localparam int          CNT_W                      = 18;
	localparam logic [5:0]  POS_MAX                    = 6'h3f;
	localparam logic [5:0]  POS_MIN                    = 6'h00;
	localparam int          SAVE_MSB                   = 5;
	localparam int          SAVE_LSB                   = 3;
	localparam int          IN_UP                      = 0;
	localparam int          IN_DOWN                    = 1;
	localparam int          IN_DIG                     = 2;

	typedef enum logic {
		PSWC_DETECT,
		PSWC_RUN
	} pswc_state_e;
endpackage

// ==== pswc_wiper_ctrl.sv ====
module pswc_wiper_ctrl #(
	parameter int MS_CYC      = pswc_pkg::MS_CYC,
	parameter int CONTACT_CYC = pswc_pkg::CONTACT_STEP_MIN_WIDTH_CYC
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       up_contact_input_n_i,
	input  wire logic       down_contact_input_n_i,
	input  wire logic       digital_step_n_i,
	input  wire logic       dual_strap_i,
	input  wire logic [5:0] nv_pos_i,
	input  wire logic       nv_worn_i,
	output logic      [5:0] wiper_o,
	output logic            dir_up_o,
	output logic            dual_mode_o,
	output logic            ready_o,
	output logic            nv_write_o,
	output logic      [5:0] nv_data_o
);
	localparam logic [pswc_pkg::CNT_W-1:0] MS_LAST  = pswc_pkg::CNT_W'(MS_CYC - 1);
	localparam logic [pswc_pkg::CNT_W-1:0] DET_LAST =
		pswc_pkg::CNT_W'(pswc_pkg::MODE_DETECT_TIME_CYC - 1);

	pswc_pkg::pswc_state_e state;
	pswc_pkg::pswc_state_e next_state;
	logic [pswc_pkg::CNT_W-1:0] ms_cnt;
	logic [pswc_pkg::CNT_W-1:0] next_ms_cnt;
	logic       ms_tick;
	logic [2:0] raw_act;
	logic [2:0] act;
	logic [2:0] act_q;
	logic [2:0] next_act_q;
	logic [2:0] press;
	logic [5:0] pos;
	logic [5:0] next_pos;
	logic       dir_up;
	logic       next_dir_up;
	logic       dual;
	logic       next_dual;
	logic [10:0] hold_cnt;
	logic [10:0] next_hold_cnt;
	logic [10:0] idle_cnt;
	logic [10:0] next_idle_cnt;
	logic [10:0] save_cnt;
	logic [10:0] next_save_cnt;
	logic       save_pend;
	logic       next_save_pend;
	logic       first_saved;
	logic       next_first_saved;
	logic [5:0] stored;
	logic [5:0] next_stored;
	logic       next_nv_write;
	logic [5:0] next_nv_data;
	logic       src_act;
	logic       do_step;
	logic       force_dir;
	logic       want_up;
	logic       eff_up;

	// (R02) Active low pins
	assign raw_act = {~digital_step_n_i, ~down_contact_input_n_i, ~up_contact_input_n_i};

	// (R20) Short gaps merge
	// Input filters: a level flips only after it stands for the full width,
	// so contact bounce and gaps shorter than the width are swallowed
	for (genvar i = 0; i < 3; i++) begin : g_filt
		localparam logic [pswc_pkg::CNT_W-1:0] LIM = (i == pswc_pkg::IN_DIG) ?
			pswc_pkg::CNT_W'(pswc_pkg::DIGITAL_STEP_MIN_WIDTH_CYC - 1) :
			pswc_pkg::CNT_W'(CONTACT_CYC - 1);
		logic [pswc_pkg::CNT_W-1:0] cnt;
		logic [pswc_pkg::CNT_W-1:0] next_cnt;
		logic                       lvl;
		logic                       next_lvl;
		// (R10) Debounce counter
		always_comb begin
			next_cnt = '0;
			next_lvl = lvl;
			if (raw_act[i] != lvl) begin
				if (cnt == LIM) begin
					next_lvl = raw_act[i];
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
		end
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cnt <= '0;
				lvl <= 1'b0;
			end else begin
				cnt <= next_cnt;
				lvl <= next_lvl;
			end
		end
		assign act[i] = lvl;
	end

	// Millisecond timebase; also times the mode detect window
	// (R22) Exact tick counts
	assign ms_tick = (state == pswc_pkg::PSWC_RUN) && (ms_cnt == MS_LAST);
	assign press   = act & ~act_q;

	always_comb begin
		next_ms_cnt = ms_cnt + 1'b1;
		if (state == pswc_pkg::PSWC_DETECT) begin
			if (ms_cnt == DET_LAST) begin
				next_ms_cnt = '0;
			end
		end else if (ms_tick) begin
			next_ms_cnt = '0;
		end
	end

	// Step source and direction; dual mode contacts force direction
	always_comb begin
		src_act   = act[pswc_pkg::IN_UP] | act[pswc_pkg::IN_DIG] |
			(dual & act[pswc_pkg::IN_DOWN]);
		force_dir = 1'b0;
		want_up   = dir_up;
		// (R08) Dual direction
		if (dual && act[pswc_pkg::IN_UP]) begin
			force_dir = 1'b1;
			want_up   = 1'b1;
		end else if (dual && act[pswc_pkg::IN_DOWN]) begin
			force_dir = 1'b1;
			want_up   = 1'b0;
		end
		// (R06) Bounce off ends
		eff_up = want_up;
		if (!force_dir && pos == pswc_pkg::POS_MAX) begin
			eff_up = 1'b0;
		end else if (!force_dir && pos == pswc_pkg::POS_MIN) begin
			eff_up = 1'b1;
		end
	end

	// Single step, hold repeat, idle reversal
	always_comb begin
		next_state    = state;
		next_pos      = pos;
		next_dir_up   = dir_up;
		next_dual     = dual;
		next_hold_cnt = hold_cnt;
		next_idle_cnt = idle_cnt;
		next_act_q    = act;
		do_step       = 1'b0;
		unique case (state)
			pswc_pkg::PSWC_DETECT: begin
				next_act_q = act_q;
				// (R17) Detect window end
				if (ms_cnt == DET_LAST) begin
					next_state = pswc_pkg::PSWC_RUN;
					// (R03) Open-pin strap
					next_dual  = dual_strap_i;
					// (R11) Restore position
					next_pos   = nv_pos_i;
				end
			end
			pswc_pkg::PSWC_RUN: begin
				// (R01) Press steps once; (R04) digital input counts in all modes
				if ((press[pswc_pkg::IN_UP] | press[pswc_pkg::IN_DIG] |
					(dual & press[pswc_pkg::IN_DOWN])) != 1'b0) begin
					do_step       = 1'b1;
					next_hold_cnt = '0;
				end else if (src_act && ms_tick) begin
					next_hold_cnt = hold_cnt + 1'b1;
					// (R05) Auto-repeat
					if (hold_cnt == pswc_pkg::HOLD_MS - 1'b1) begin
						do_step       = 1'b1;
						next_hold_cnt = pswc_pkg::HOLD_MS - pswc_pkg::REPEAT_MS;
					end
				end
				if (src_act) begin
					next_idle_cnt = '0;
				end else if (ms_tick && idle_cnt != pswc_pkg::IDLE_MS) begin
					next_idle_cnt = idle_cnt + 1'b1;
					// (R07) Idle reversal; (R21) shorter gaps keep direction
					if (idle_cnt == pswc_pkg::IDLE_MS - 1'b1 && !dual) begin
						next_dir_up = ~dir_up;
					end
				end
				if (do_step) begin
					// (R09) Dual mode clamps at ends
					if (force_dir && ((eff_up && pos == pswc_pkg::POS_MAX) ||
						(!eff_up && pos == pswc_pkg::POS_MIN))) begin
						next_pos = pos;
					// (R23) Clamped counter
					end else if (eff_up) begin
						next_pos = pos + 1'b1;
					end else begin
						next_pos = pos - 1'b1;
					end
					next_dir_up = eff_up;
					// (R06) Reverse on reaching end
					if (!force_dir && (next_pos == pswc_pkg::POS_MAX ||
						next_pos == pswc_pkg::POS_MIN)) begin
						next_dir_up = ~eff_up;
					end
				end
			end
		endcase
	end

	// Nonvolatile save scheduling
	always_comb begin
		next_save_cnt    = save_cnt;
		next_save_pend   = save_pend;
		next_first_saved = first_saved;
		next_stored      = stored;
		next_nv_write    = 1'b0;
		next_nv_data     = nv_data_o;
		if (state == pswc_pkg::PSWC_DETECT) begin
			next_stored = nv_pos_i;
		end else if (next_pos != pos) begin
			// (R12) Restart two second delay on every change
			next_save_pend = 1'b1;
			next_save_cnt  = '0;
		end else if (save_pend && ms_tick) begin
			next_save_cnt = save_cnt + 1'b1;
			if (save_cnt == pswc_pkg::SAVE_MS - 1'b1) begin
				next_save_pend = 1'b0;
				// (R13) First change; (R14) fourth bit change
				if (!first_saved || pos[pswc_pkg::SAVE_MSB:pswc_pkg::SAVE_LSB] !=
					stored[pswc_pkg::SAVE_MSB:pswc_pkg::SAVE_LSB]) begin
					next_first_saved = 1'b1;
					next_stored      = pos;
					next_nv_data     = pos;
					// (R16) Worn cells take no write
					next_nv_write    = ~nv_worn_i;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state       <= pswc_pkg::PSWC_DETECT;
			ms_cnt      <= '0;
			act_q       <= 3'h0;
			pos         <= 6'h00;
			dir_up      <= 1'b1;
			dual        <= 1'b0;
			hold_cnt    <= 11'h000;
			idle_cnt    <= 11'h000;
			save_cnt    <= 11'h000;
			save_pend   <= 1'b0;
			first_saved <= 1'b0;
			stored      <= 6'h00;
			nv_write_o  <= 1'b0;
			nv_data_o   <= 6'h00;
		end else begin
			state       <= next_state;
			ms_cnt      <= next_ms_cnt;
			act_q       <= next_act_q;
			pos         <= next_pos;
			dir_up      <= next_dir_up;
			dual        <= next_dual;
			hold_cnt    <= next_hold_cnt;
			idle_cnt    <= next_idle_cnt;
			save_cnt    <= next_save_cnt;
			save_pend   <= next_save_pend;
			first_saved <= next_first_saved;
			stored      <= next_stored;
			nv_write_o  <= next_nv_write;
			nv_data_o   <= next_nv_data;
		end
	end

	assign wiper_o     = pos;
	assign dir_up_o    = dir_up;
	assign dual_mode_o = dual;
	assign ready_o     = (state == pswc_pkg::PSWC_RUN);
endmodule

// ==== pswc_wiper_props.sv ====
module pswc_wiper_props (
	input wire logic       clk_sys_i,
	input wire logic       rst_n_i,
	input wire logic       up_contact_input_n_i,
	input wire logic       down_contact_input_n_i,
	input wire logic       digital_step_n_i,
	input wire logic       dual_strap_i,
	input wire logic [5:0] nv_pos_i,
	input wire logic       nv_worn_i,
	input wire logic [5:0] wiper_o,
	input wire logic       dir_up_o,
	input wire logic       dual_mode_o,
	input wire logic       ready_o,
	input wire logic       nv_write_o,
	input wire logic [5:0] nv_data_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	logic [11:0] det_cnt;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			det_cnt <= 12'h000;
		else if (!ready_o)
			det_cnt <= det_cnt + 12'h001;
	end
	step_size_a: assert property ($past(ready_o) && $changed(wiper_o) |->
		wiper_o == $past(wiper_o) + 6'h01 || wiper_o == $past(wiper_o) - 6'h01) else $error("jump");
	step_cause_a: assert property ($past(ready_o) && $changed(wiper_o) |->
		!$past(up_contact_input_n_i, 2) || !$past(down_contact_input_n_i, 2)
		|| !$past(digital_step_n_i, 2)) else $error("step without press");
	no_wrap_a: assert property ($past(ready_o) |->
		!($past(wiper_o) == 6'h3f && wiper_o == 6'h00)
		&& !($past(wiper_o) == 6'h00 && wiper_o == 6'h3f)) else $error("wrap");
	load_nv_a: assert property ($rose(ready_o) |-> wiper_o == $past(nv_pos_i)
		&& dual_mode_o == $past(dual_strap_i)) else $error("bad load");
	detect_time_a: assert property (!ready_o |-> det_cnt < 12'h7d1)
		else $error("detect slow");
	end_turn_a: assert property (!dual_mode_o && $past(ready_o) && $changed(wiper_o)
		&& (wiper_o == 6'h3f || wiper_o == 6'h00) |-> ##[0:1] dir_up_o == (wiper_o == 6'h00))
		else $error("no reverse");
	dual_hold_a: assert property (dual_mode_o && $past(ready_o) && $changed(wiper_o)
		&& wiper_o == 6'h3f && !$past(up_contact_input_n_i, 2) |-> ##[0:1] dir_up_o)
		else $error("dual reversed");
	worn_block_a: assert property ($past(nv_worn_i) |-> !nv_write_o)
		else $error("write to worn cells");
	save_data_a: assert property (nv_write_o |-> nv_data_o == wiper_o
		&& wiper_o == $past(wiper_o, 8)) else $error("bad save");
endmodule
bind pswc_wiper_ctrl pswc_wiper_props u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.up_contact_input_n_i(up_contact_input_n_i), .down_contact_input_n_i(down_contact_input_n_i),
	.digital_step_n_i(digital_step_n_i), .dual_strap_i(dual_strap_i), .nv_pos_i(nv_pos_i),
	.nv_worn_i(nv_worn_i), .wiper_o(wiper_o), .dir_up_o(dir_up_o), .dual_mode_o(dual_mode_o),
	.ready_o(ready_o), .nv_write_o(nv_write_o), .nv_data_o(nv_data_o));

// ==== pswc_button_model.sv ====
module pswc_button_model (
	input  wire logic       clk_i,
	output logic      [2:0] pin_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial pin_n_o = 3'h7;
	// low for len, then a long gap so pulses never merge
	task automatic press(input int sel, input int len);
		@(posedge clk_i);
		#1 pin_n_o[sel] = 1'b0;
		repeat (len) @(posedge clk_i);
		#1 pin_n_o[sel] = 1'b1;
		repeat (300) @(posedge clk_i);
	endtask
endmodule

// ==== pswc_wiper_ctrl_test.sv ====
module pswc_wiper_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_sys_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       dual_strap_i = 1'b0;
	logic [5:0] nv_pos_i = 6'h3d;
	logic       nv_worn_i = 1'b0;
	logic [2:0] pin_n;
	logic [5:0] wiper_o, nv_data_o;
	logic       dir_up_o, dual_mode_o, ready_o, nv_write_o;
	int         fail_count = 0, num_checks = 0, cycles = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	pswc_button_model u_pswc_button_model (.clk_i(clk_sys_i), .pin_n_o(pin_n));
	// Short ms tick keeps the hold and save waits within the run budget
	pswc_wiper_ctrl #(.MS_CYC(5), .CONTACT_CYC(20)) u_pswc_wiper_ctrl (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .up_contact_input_n_i(pin_n[0]),
		.down_contact_input_n_i(pin_n[1]), .digital_step_n_i(pin_n[2]),
		.dual_strap_i(dual_strap_i), .nv_pos_i(nv_pos_i), .nv_worn_i(nv_worn_i),
		.wiper_o(wiper_o), .dir_up_o(dir_up_o), .dual_mode_o(dual_mode_o), .ready_o(ready_o),
		.nv_write_o(nv_write_o), .nv_data_o(nv_data_o));
	task automatic chk(input logic [5:0] got, input logic [5:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 80000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic t_start(input logic dual, input logic [5:0] pos);
		int n;
		@(posedge clk_sys_i);
		#1 rst_n_i = 1'b0;
		dual_strap_i = dual;
		nv_pos_i = pos;
		repeat (2) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		for (n = 0; n < pswc_pkg::MODE_DETECT_TIME_CYC && ready_o !== 1'b1; n++) begin
			@(posedge clk_sys_i);
			#1;
		end
		chk({5'h00, ready_o}, 6'h01);
		chk(wiper_o, pos);
		chk({5'h00, dual_mode_o}, {5'h00, dual});
		$display("start done");
	endtask
	task automatic t_single();
		u_pswc_button_model.press(2, 250);
		chk(wiper_o, 6'h3e);
		u_pswc_button_model.press(2, 250);
		chk(wiper_o, 6'h3f);
		chk({5'h00, dir_up_o}, 6'h00);
		u_pswc_button_model.press(2, 100);
		chk(wiper_o, 6'h3f);
		u_pswc_button_model.press(0, 30);
		chk(wiper_o, 6'h3e);
		u_pswc_button_model.press(0, 6250);
		chk(wiper_o, 6'h3a);
		chk({5'h00, dir_up_o}, 6'h00);
		$display("single done");
	endtask
	task automatic wait_write(input int lim);
		int n;
		for (n = 0; n < lim && nv_write_o !== 1'b1; n++) begin
			@(posedge clk_sys_i);
			#1;
		end
	endtask
	task automatic t_save();
		wait_write(12000);
		chk({5'h00, nv_write_o}, 6'h01);
		chk(nv_data_o, 6'h3a);
		chk({5'h00, dir_up_o}, 6'h01);
		$display("save done");
	endtask
	task automatic t_keep();
		int n;
		u_pswc_button_model.press(2, 250);
		chk(wiper_o, 6'h3b);
		wait_write(12000);
		chk({5'h00, nv_write_o}, 6'h00);
		chk({5'h00, dir_up_o}, 6'h00);
		for (n = 0; n < 4; n++) begin
			u_pswc_button_model.press(2, 250);
		end
		chk(wiper_o, 6'h37);
		wait_write(12000);
		chk({5'h00, nv_write_o}, 6'h01);
		chk(nv_data_o, 6'h37);
		$display("keep done");
	endtask
	task automatic t_dual();
		t_start(1'b1, 6'h3e);
		nv_worn_i = 1'b1;
		u_pswc_button_model.press(0, 30);
		chk(wiper_o, 6'h3f);
		u_pswc_button_model.press(0, 30);
		chk(wiper_o, 6'h3f);
		chk({5'h00, dir_up_o}, 6'h01);
		u_pswc_button_model.press(1, 30);
		chk(wiper_o, 6'h3e);
		u_pswc_button_model.press(0, 10);
		chk(wiper_o, 6'h3e);
		u_pswc_button_model.press(2, 250);
		chk(wiper_o, 6'h3d);
		wait_write(12000);
		chk({5'h00, nv_write_o}, 6'h00);
		$display("dual done");
	endtask
	initial begin
		t_start(1'b0, 6'h3d);
		t_single();
		t_save();
		t_keep();
		t_dual();
		end_sim();
	end
endmodule
